// File: csf_regs.vh
// register map, field positions, reset values and operation codes of the flag and table-read block
// assumes an apb slave with 32-bit data, one aligned word per register
`ifndef CSF_REGS_VH
`define CSF_REGS_VH

// register byte offsets
`define CSF_OFS_FLAGS       8'h00
`define CSF_OFS_TBL_PTR_LO  8'h04
`define CSF_OFS_TBL_PTR_HI  8'h08
`define CSF_OFS_TBL_HI_LAT  8'h0c
`define CSF_OFS_INT_STATUS  8'h10
`define CSF_OFS_INT_MASK    8'h14
`define CSF_OFS_TBL_CTRL    8'h18

// flag register field positions
`define CSF_FLAG_C    0
`define CSF_FLAG_AC   1
`define CSF_FLAG_Z    2
`define CSF_FLAG_OV   3
`define CSF_FLAG_PDF  4
`define CSF_FLAG_TO   5

// interrupt status field positions
`define CSF_INT_TBL_DONE  0
`define CSF_INT_WDT_EXP   1
`define CSF_INT_OVERFLOW  2

// table control field positions
`define CSF_CTRL_START  0
`define CSF_CTRL_BUSY   1

// reset values
`define CSF_RST_FLAGS    6'h00
`define CSF_RST_PTR      8'h00
`define CSF_RST_LATCH    8'h00
`define CSF_RST_INT      3'h0

// alu operation codes
`define CSF_OP_ADD  4'h0
`define CSF_OP_ADC  4'h1
`define CSF_OP_SUB  4'h2
`define CSF_OP_SBC  4'h3
`define CSF_OP_AND  4'h4
`define CSF_OP_OR   4'h5
`define CSF_OP_XOR  4'h6
`define CSF_OP_RLC  4'h7
`define CSF_OP_RRC  4'h8
`define CSF_OP_PASS 4'h9

`endif

// File: csf_flag_alu.v
// combinational alu core that produces a result and the four condition flags
// assumes the caller registers the outputs and supplies the current carry flag
`timescale 1ns/1ps
`include "csf_regs.vh"

module csf_flag_alu (
  op,
  opa,
  opb,
  carry_in,
  result,
  flag_val,
  flag_upd
);
  input  wire [3:0] op;
  input  wire [7:0] opa;
  input  wire [7:0] opb;
  input  wire       carry_in;
  output reg  [7:0] result;
  output reg  [3:0] flag_val;
  output reg  [3:0] flag_upd;

  reg  [4:0] low_sum;
  reg  [7:0] low7_sum;
  reg  [8:0] full_sum;
  reg  [7:0] b_eff;
  reg        cin_eff;
  reg        arith;

  // subtraction is a + ~b + 1, so carry out means no borrow
  always @* begin
    arith    = 1'b0;
    b_eff    = opb;
    cin_eff  = 1'b0;
    result   = opa;
    flag_upd = 4'h0;
    case (op)
      `CSF_OP_ADD: begin arith = 1'b1; end
      `CSF_OP_ADC: begin arith = 1'b1; cin_eff = carry_in; end
      `CSF_OP_SUB: begin arith = 1'b1; b_eff = ~opb; cin_eff = 1'b1; end
      `CSF_OP_SBC: begin arith = 1'b1; b_eff = ~opb; cin_eff = carry_in; end
      default: begin arith = 1'b0; end
    endcase
    low_sum  = {1'b0, opa[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
    low7_sum = {1'b0, opa[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin_eff};
    full_sum = {1'b0, opa} + {1'b0, b_eff} + {8'h00, cin_eff};
    flag_val[`CSF_FLAG_C]  = full_sum[8];
    flag_val[`CSF_FLAG_AC] = low_sum[4];
    flag_val[`CSF_FLAG_OV] = low7_sum[7] ^ full_sum[8];
    case (op)
      `CSF_OP_AND: result = opa & opb;
      `CSF_OP_OR:  result = opa | opb;
      `CSF_OP_XOR: result = opa ^ opb;
      `CSF_OP_RLC: begin
        result = {opa[6:0], carry_in};
        flag_val[`CSF_FLAG_C] = opa[7];
      end
      `CSF_OP_RRC: begin
        result = {carry_in, opa[7:1]};
        flag_val[`CSF_FLAG_C] = opa[0];
      end
      `CSF_OP_PASS: result = opa;
      default: result = full_sum[7:0];
    endcase
    flag_val[`CSF_FLAG_Z] = (result == 8'h00);
    if (arith) begin
      flag_upd = 4'hf;
    end else if ((op == `CSF_OP_RLC) || (op == `CSF_OP_RRC)) begin
      flag_upd[`CSF_FLAG_C] = 1'b1;
    end else if (op != `CSF_OP_PASS) begin
      flag_upd[`CSF_FLAG_Z] = 1'b1;
    end
  end
endmodule // csf_flag_alu

// File: csf_status_table.v
// condition and system flag register with table-read pointers and high-byte latch, apb slave
// assumes every core-side input is driven by logic on pclk and program memory answers with a valid strobe
//
// Contract
// - a table read fetches the program word at the address formed by the high and low table pointers.
// - after a table read the high byte goes to the latch and the low byte to the instruction's destination.
// - the table pointers are plain writable registers that increment and decrement can change in place.
// - the flag register is 8 bits, flags in bits 5 to 0, bits 7 and 6 read zero.
// - writes alter the four arithmetic flags only; time-out and power-down flags are read only.
// - the time-out flag clears on power-up, watchdog clear or sleep and sets on watchdog expiry only.
// - the power-down flag clears on power-up or watchdog clear and sets on sleep only.
// - carry is set on an addition carry out or a subtraction without borrow, else cleared.
// - rotate through carry loads carry with the bit shifted out.
// - half carry is set on a carry out of the low nibble or no borrow into it, else cleared.
// - zero is set when an arithmetic or logical result is zero, else cleared.
// - overflow is set when carry into the top bit differs from carry out of it.
// - interrupt entry and calls never save the flag register automatically.
`timescale 1ns/1ps
`include "csf_regs.vh"

module csf_status_table (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  alu_valid,
  alu_op,
  alu_opa,
  alu_opb,
  alu_result,
  flag_wr,
  flag_wdata,
  flags,
  wdt_expire,
  sleep_instr,
  watchdog_clear_instruction,
  ptr_wr,
  ptr_inc,
  ptr_dec,
  ptr_wdata,
  tbl_read_req,
  prog_rd,
  prog_addr,
  prog_data,
  prog_data_valid,
  tbl_low_byte,
  tbl_low_valid,
  irq
);
  input  wire        pclk;
  input  wire        presetn;
  input  wire        psel;
  input  wire        penable;
  input  wire        pwrite;
  input  wire [7:0]  paddr;
  input  wire [31:0] pwdata;
  output wire [31:0] prdata;
  output wire        pready;
  output wire        pslverr;
  input  wire        alu_valid;
  input  wire [3:0]  alu_op;
  input  wire [7:0]  alu_opa;
  input  wire [7:0]  alu_opb;
  output wire [7:0]  alu_result;
  input  wire        flag_wr;
  input  wire [7:0]  flag_wdata;
  output wire [7:0]  flags;
  input  wire        wdt_expire;
  input  wire        sleep_instr;
  input  wire        watchdog_clear_instruction;
  input  wire [1:0]  ptr_wr;
  input  wire [1:0]  ptr_inc;
  input  wire [1:0]  ptr_dec;
  input  wire [7:0]  ptr_wdata;
  input  wire        tbl_read_req;
  output wire        prog_rd;
  output wire [15:0] prog_addr;
  input  wire [15:0] prog_data;
  input  wire        prog_data_valid;
  output wire [7:0]  tbl_low_byte;
  output wire        tbl_low_valid;
  output wire        irq;

  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_FETCH = 3'b010;
  localparam [2:0] ST_DONE  = 3'b100;

  reg  [5:0]  flags_ff;
  reg  [5:0]  nxt_flags;
  reg  [7:0]  ptr_ff [0:1];
  reg  [7:0]  latch_ff;
  reg  [7:0]  alu_result_ff;
  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg         prog_rd_ff;
  reg  [15:0] prog_addr_ff;
  reg  [7:0]  low_byte_ff;
  reg         low_valid_ff;
  reg  [2:0]  int_status_ff;
  reg  [2:0]  nxt_int_status;
  reg  [2:0]  int_mask_ff;
  reg         irq_ff;
  reg         pready_ff;
  reg         pslverr_ff;
  reg  [31:0] prdata_ff;
  reg  [31:0] rd_mux;
  reg         addr_hit;
  wire        apb_acc;
  wire        apb_wr;
  wire [7:0]  alu_res;
  wire [3:0]  alu_flag_val;
  wire [3:0]  alu_flag_upd;
  wire        sw_start;
  wire        tbl_start;
  wire        ovf_event;

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: answer in the second access cycle so all read data comes from flops

  assign apb_acc = psel & penable & ~pready_ff;
  assign apb_wr  = apb_acc & pwrite & addr_hit;

  // address decode and read mux; bits above each register read zero
  always @* begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (paddr)
      `CSF_OFS_FLAGS:      rd_mux[5:0] = flags_ff;
      `CSF_OFS_TBL_PTR_LO: rd_mux[7:0] = ptr_ff[0];
      `CSF_OFS_TBL_PTR_HI: rd_mux[7:0] = ptr_ff[1];
      `CSF_OFS_TBL_HI_LAT: rd_mux[7:0] = latch_ff;
      `CSF_OFS_INT_STATUS: rd_mux[2:0] = int_status_ff;
      `CSF_OFS_INT_MASK:   rd_mux[2:0] = int_mask_ff;
      `CSF_OFS_TBL_CTRL:   rd_mux[`CSF_CTRL_BUSY] = ~state_ff[0];
      default:             addr_hit = 1'b0;
    endcase
  end

  // bus answer flops; unmapped addresses get pslverr, writes to them are dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= apb_acc;
      pslverr_ff <= apb_acc & ~addr_hit;
      if (apb_acc && !pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // alu and flag register

  csf_flag_alu u_alu (
    .op       (alu_op),
    .opa      (alu_opa),
    .opb      (alu_opb),
    .carry_in (flags_ff[`CSF_FLAG_C]),
    .result   (alu_res),
    .flag_val (alu_flag_val),
    .flag_upd (alu_flag_upd)
  );

  // later assignments win: core write over alu over apb write; system bits set over clear
  always @* begin : flag_next
    integer i;
    nxt_flags = flags_ff;
    if (apb_wr && (paddr == `CSF_OFS_FLAGS)) begin
      nxt_flags[3:0] = pwdata[3:0];
    end
    for (i = 0; i < 4; i = i + 1) begin
      if (alu_valid && alu_flag_upd[i]) begin
        nxt_flags[i] = alu_flag_val[i];
      end
    end
    if (flag_wr) begin
      nxt_flags[3:0] = flag_wdata[3:0];
    end
    if (watchdog_clear_instruction || sleep_instr) begin
      nxt_flags[`CSF_FLAG_TO] = 1'b0;
    end
    if (wdt_expire) begin
      nxt_flags[`CSF_FLAG_TO] = 1'b1;
    end
    if (watchdog_clear_instruction) begin
      nxt_flags[`CSF_FLAG_PDF] = 1'b0;
    end
    if (sleep_instr) begin
      nxt_flags[`CSF_FLAG_PDF] = 1'b1;
    end
  end

  // power-up clears everything; there is no path that pushes flags anywhere
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff      <= `CSF_RST_FLAGS;
      alu_result_ff <= 8'h00;
    end else begin
      flags_ff <= nxt_flags;
      if (alu_valid) begin
        alu_result_ff <= alu_res;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // table pointers: low and high bytes wrap on their own, no carry between them

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ptr
      wire apb_ptr_wr;
      assign apb_ptr_wr = apb_wr &&
                          (paddr == ((g == 0) ? `CSF_OFS_TBL_PTR_LO : `CSF_OFS_TBL_PTR_HI));
      // core write beats step beats apb write
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ptr_ff[g] <= `CSF_RST_PTR;
        end else if (ptr_wr[g]) begin
          ptr_ff[g] <= ptr_wdata;
        end else if (ptr_inc[g]) begin
          ptr_ff[g] <= ptr_ff[g] + 8'h01;
        end else if (ptr_dec[g]) begin
          ptr_ff[g] <= ptr_ff[g] - 8'h01;
        end else if (apb_ptr_wr) begin
          ptr_ff[g] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // table read sequencer

  assign sw_start  = apb_wr && (paddr == `CSF_OFS_TBL_CTRL) && pwdata[`CSF_CTRL_START];
  assign tbl_start = tbl_read_req | sw_start;

  // requests while busy are ignored, also in the low-byte strobe cycle; the core must wait until after the strobe
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:  if (tbl_start) nxt_state = ST_FETCH;
      ST_FETCH: if (prog_data_valid) nxt_state = ST_DONE;
      ST_DONE:  nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  // address is sampled from the pointers when the read starts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= ST_IDLE;
      prog_rd_ff   <= 1'b0;
      prog_addr_ff <= 16'h0000;
      latch_ff     <= `CSF_RST_LATCH;
      low_byte_ff  <= 8'h00;
      low_valid_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      low_valid_ff <= 1'b0;
      if (state_ff[0] && tbl_start) begin
        prog_rd_ff   <= 1'b1;
        prog_addr_ff <= {ptr_ff[1], ptr_ff[0]};
      end
      if (state_ff[1] && prog_data_valid) begin
        prog_rd_ff   <= 1'b0;
        latch_ff     <= prog_data[15:8];
        low_byte_ff  <= prog_data[7:0];
        low_valid_ff <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky events, write one to clear, set wins over clear

  assign ovf_event = alu_valid & alu_flag_upd[`CSF_FLAG_OV] & alu_flag_val[`CSF_FLAG_OV];

  always @* begin
    nxt_int_status = int_status_ff;
    if (apb_wr && (paddr == `CSF_OFS_INT_STATUS)) begin
      nxt_int_status = int_status_ff & ~pwdata[2:0];
    end
    if (state_ff[1] && prog_data_valid) begin
      nxt_int_status[`CSF_INT_TBL_DONE] = 1'b1;
    end
    if (wdt_expire) begin
      nxt_int_status[`CSF_INT_WDT_EXP] = 1'b1;
    end
    if (ovf_event) begin
      nxt_int_status[`CSF_INT_OVERFLOW] = 1'b1;
    end
  end

  // irq follows status and mask one cycle later so it leaves a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_ff <= `CSF_RST_INT;
      int_mask_ff   <= `CSF_RST_INT;
      irq_ff        <= 1'b0;
    end else begin
      int_status_ff <= nxt_int_status;
      if (apb_wr && (paddr == `CSF_OFS_INT_MASK)) begin
        int_mask_ff <= pwdata[2:0];
      end
      irq_ff <= |(int_status_ff & int_mask_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign alu_result    = alu_result_ff;
  assign flags         = {2'b00, flags_ff};
  assign prog_rd       = prog_rd_ff;
  assign prog_addr     = prog_addr_ff;
  assign tbl_low_byte  = low_byte_ff;
  assign tbl_low_valid = low_valid_ff;
  assign irq           = irq_ff;

endmodule // csf_status_table

// File: csf_checker.sv
// concurrent checks on the flag and table-read block
// assumes it is bound to the block and sees only its ports
`timescale 1ns/1ps
`include "csf_regs.vh"
module csf_checker (
  input wire       pclk,
  input wire       presetn,
  input wire       alu_valid,
  input wire [3:0] alu_op,
  input wire [7:0] alu_opa,
  input wire [7:0] alu_opb,
  input wire [7:0] alu_result,
  input wire       flag_wr,
  input wire [7:0] flag_wdata,
  input wire [7:0] flags,
  input wire       wdt_expire,
  input wire       sleep_instr,
  input wire       watchdog_clear_instruction,
  input wire       prog_rd,
  input wire [15:0] prog_addr,
  input wire [15:0] prog_data,
  input wire       prog_data_valid,
  input wire [7:0] tbl_low_byte,
  input wire       tbl_low_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire sys_ev = wdt_expire | sleep_instr | watchdog_clear_instruction;
  ////////////////////
  // flag register: top bits read zero, system flags move only on their own events, core write lands
  unused_bits_a: assert property (flags[7:6] == 2'b00) else $error("top flag bits set");
  to_set_a: assert property (wdt_expire |=> flags[5]) else $error("time-out flag not set");
  to_clear_a: assert property ((sleep_instr | watchdog_clear_instruction) && !wdt_expire |=> !flags[5])
    else $error("time-out flag not cleared");
  pdf_set_a: assert property (sleep_instr |=> flags[4]) else $error("power-down flag not set");
  pdf_clear_a: assert property (watchdog_clear_instruction && !sleep_instr |=> !flags[4])
    else $error("power-down flag not cleared");
  sys_hold_a: assert property (!sys_ev |=> $stable(flags[5:4])) else $error("system flags moved");
  flag_write_a: assert property (flag_wr |=> flags[3:0] == $past(flag_wdata[3:0]))
    else $error("flag write lost");
  ////////////////////
  // alu flags, the core write has priority so it is excluded
  add_carry_a: assert property (alu_valid && alu_op == `CSF_OP_ADD && !flag_wr |=>
    {flags[0], alu_result} == $past({1'b0, alu_opa} + alu_opb)) else $error("add carry wrong");
  zero_logic_a: assert property (alu_valid && !flag_wr && alu_op inside {`CSF_OP_AND, `CSF_OP_OR, `CSF_OP_XOR}
    |=> flags[2] == (alu_result == 8'h00)) else $error("zero flag wrong");
  ////////////////////
  // table fetch keeps its address and returns the low byte
  fetch_hold_a: assert property (prog_rd && !prog_data_valid |=> prog_rd && $stable(prog_addr))
    else $error("fetch address moved");
  low_byte_a: assert property (prog_rd && prog_data_valid |=> tbl_low_valid &&
    tbl_low_byte == $past(prog_data[7:0])) else $error("low byte wrong");
  cover property (tbl_low_valid);
  cover property (wdt_expire ##1 flags[5]);
  cover property (alu_valid && alu_op == `CSF_OP_SBC);
endmodule // csf_checker

// File: csf_prog_mem.sv
// program memory model answering table fetches
// assumes the fetch request stays high until the data strobe is seen
`timescale 1ns/1ps
module csf_prog_mem (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        rd,
  input  wire [15:0] addr,
  input  wire [7:0]  dly,
  output logic [15:0] data,
  output logic        valid
);
  int n;
  // word is address xor a pattern; data toggles while no fetch is counting down and holds during the count, so stale values never match
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n <= 0;
      valid <= 1'b0;
      data <= 16'h0000;
    end else if (rd && !valid) begin
      if (n >= dly) begin
        valid <= 1'b1;
        data <= addr ^ 16'ha55a;
        n <= 0;
      end else begin
        n <= n + 1;
      end
    end else begin
      valid <= 1'b0;
      data <= ~data;
    end
  end
endmodule // csf_prog_mem

// File: csf_status_table_tb_top.sv
// self-checking bench for the flag and table-read block
// assumes the block, its header, the memory model and the checker are compiled first
`timescale 1ns/1ps
`include "csf_regs.vh"
module csf_status_table_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, alu_valid, flag_wr;
  logic        wdt_expire, sleep_instr, watchdog_clear_instruction, tbl_read_req, prog_rd;
  logic        prog_data_valid, tbl_low_valid, irq, last_err;
  logic [7:0]  paddr, alu_opa, alu_opb, alu_result, flag_wdata, flags, ptr_wdata, tbl_low_byte, dly;
  logic [3:0]  alu_op;
  logic [1:0]  ptr_wr, ptr_inc, ptr_dec;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] prog_addr, prog_data;
  int          err_total, n_checks;
  csf_status_table csf_status_table_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alu_valid(alu_valid), .alu_op(alu_op), .alu_opa(alu_opa), .alu_opb(alu_opb), .alu_result(alu_result),
    .flag_wr(flag_wr), .flag_wdata(flag_wdata), .flags(flags), .wdt_expire(wdt_expire),
    .sleep_instr(sleep_instr), .watchdog_clear_instruction(watchdog_clear_instruction), .ptr_wr(ptr_wr),
    .ptr_inc(ptr_inc), .ptr_dec(ptr_dec), .ptr_wdata(ptr_wdata), .tbl_read_req(tbl_read_req),
    .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data), .prog_data_valid(prog_data_valid),
    .tbl_low_byte(tbl_low_byte), .tbl_low_valid(tbl_low_valid), .irq(irq));
  csf_prog_mem csf_prog_mem_i (.clk(pclk), .rst_n(presetn), .rd(prog_rd), .addr(prog_addr), .dly(dly),
    .data(prog_data), .valid(prog_data_valid));
  ////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %0t got %h exp %h", $time, g, e);
    end
  endtask
  task stop_test;
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // apb master: request held until pready is seen high at an edge
  // one idle edge after release, so a following call never drives psel twice in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    last_err = pslverr;
    if (n >= 20) chk(1'b0, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  // one-cycle pulse of {clear, sleep, expiry}, then let its edge land
  task ev(input logic [2:0] e);
    {watchdog_clear_instruction, sleep_instr, wdt_expire} <= e;
    @(posedge pclk);
    {watchdog_clear_instruction, sleep_instr, wdt_expire} <= 3'b000;
    @(posedge pclk);
  endtask
  ////////////////////
  task t_apb;
    apb(1'b1, `CSF_OFS_FLAGS, 32'hff, r);
    rd(`CSF_OFS_FLAGS, 32'h0f);
    apb(1'b1, 8'h1c, 32'h1, r);
    chk(last_err, 1'b1);
    rd(8'h1c, 32'h0);
  endtask
  task t_sys;
    ev(3'b001);
    chk(flags, 8'h2f);
    flag_wr <= 1'b1;
    flag_wdata <= 8'hf0;
    @(posedge pclk);
    flag_wr <= 1'b0;
    @(posedge pclk);
    chk(flags, 8'h20);
    ev(3'b010);
    chk(flags, 8'h10);
    ev(3'b001);
    apb(1'b1, `CSF_OFS_FLAGS, 32'h0, r);
    chk(flags, 8'h30);
    ev(3'b100);
    chk(flags, 8'h00);
  endtask
  // {op, a, b, result, ov z ac c}; each row from the xor onwards depends on the carry left by the one before
  task t_alu;
    logic [31:0] tv [11];
    tv = '{32'h07f0180a, 32'h210010f1, 32'h20505007, 32'h65a5a007, 32'h50100013, 32'h80200812,
           32'h78100023, 32'h1ff00007, 32'h380017f9, 32'h4f00f00d, 32'h9123412d};
    foreach (tv[i]) begin
      {alu_op, alu_opa, alu_opb} <= tv[i][31:12];
      alu_valid <= 1'b1;
      @(posedge pclk);
      alu_valid <= 1'b0;
      @(posedge pclk);
      chk(alu_result, tv[i][11:4]);
      chk(flags, {4'h0, tv[i][3:0]});
    end
  endtask
  // waits for the table read to finish, checks both bytes and the done interrupt
  task tread(input logic [15:0] a);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tbl_low_valid !== 1'b1 && n < 20);
    if (n >= 20) chk(1'b0, 1'b1);
    chk(tbl_low_byte, a[7:0] ^ 8'h5a);
    @(posedge pclk);
    @(posedge pclk);
    chk(prog_rd, 1'b0);
    chk(irq, 1'b1);
    rd(`CSF_OFS_TBL_HI_LAT, {24'h0, a[15:8] ^ 8'ha5});
    rd(`CSF_OFS_INT_STATUS, 32'h1);
    apb(1'b1, `CSF_OFS_INT_STATUS, 32'h1, r);
    @(posedge pclk);
    @(posedge pclk);
    chk(irq, 1'b0);
  endtask
  task t_table;
    rd(`CSF_OFS_INT_STATUS, 32'h6);
    apb(1'b1, `CSF_OFS_INT_STATUS, 32'h7, r);
    apb(1'b1, `CSF_OFS_INT_MASK, 32'h1, r);
    apb(1'b1, `CSF_OFS_TBL_PTR_HI, 32'h12, r);
    ptr_wr <= 2'b01;
    ptr_wdata <= 8'hfe;
    @(posedge pclk);
    ptr_wr <= 2'b00;
    ptr_inc <= 2'b01;
    ptr_dec <= 2'b10;
    repeat (2) @(posedge pclk);
    ptr_inc <= 2'b00;
    ptr_dec <= 2'b00;
    rd(`CSF_OFS_TBL_PTR_LO, 32'h0);
    rd(`CSF_OFS_TBL_PTR_HI, 32'h10);
    dly <= 8'h05;
    tbl_read_req <= 1'b1;
    @(posedge pclk);
    tbl_read_req <= 1'b0;
    @(posedge pclk);
    chk(prog_rd, 1'b1);
    chk(prog_addr, 16'h1000);
    rd(`CSF_OFS_TBL_CTRL, 32'h2);
    tread(16'h1000);
    dly <= 8'h00;
    ptr_inc <= 2'b01;
    @(posedge pclk);
    ptr_inc <= 2'b00;
    apb(1'b1, `CSF_OFS_TBL_CTRL, 32'h1, r);
    tread(16'h1001);
  endtask
  ////////////////////
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (3000) @(posedge pclk);
    err_total++;
    $display("unexpected %0t timeout", $time);
    stop_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, alu_valid, flag_wr, wdt_expire, sleep_instr} = 8'h00;
    {watchdog_clear_instruction, tbl_read_req, ptr_wr, ptr_inc, ptr_dec} = 8'h00;
    {paddr, pwdata, alu_op, alu_opa, alu_opb, flag_wdata, ptr_wdata, dly} = 84'h0;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(flags, 8'h00);
    t_apb;
    t_sys;
    t_alu;
    t_table;
    stop_test;
  end
endmodule // csf_status_table_tb_top
bind csf_status_table csf_checker csf_checker_i (.pclk(pclk), .presetn(presetn), .alu_valid(alu_valid),
  .alu_op(alu_op), .alu_opa(alu_opa), .alu_opb(alu_opb), .alu_result(alu_result), .flag_wr(flag_wr),
  .flag_wdata(flag_wdata), .flags(flags), .wdt_expire(wdt_expire), .sleep_instr(sleep_instr),
  .watchdog_clear_instruction(watchdog_clear_instruction), .prog_rd(prog_rd), .prog_addr(prog_addr),
  .prog_data(prog_data), .prog_data_valid(prog_data_valid), .tbl_low_byte(tbl_low_byte),
  .tbl_low_valid(tbl_low_valid));
